// [verilog/can_mode_pkg.sv]
// Shared constants, codes and carriers of the CAN mode control and diagnostics block
package can_mode_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERRCODE = 8'h08;
  localparam logic [7:0] ADDR_STAMP  = 8'h0C;
  localparam logic [7:0] ADDR_TEST   = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_OPMODE_LSB   = 0;
  localparam int CTRL_BUSOFF_LSB   = 2;
  localparam int CTRL_PRESCALE_LSB = 4;
  localparam int CTRL_SLEEP_BIT    = 6;
  localparam int STAT_RESET_BIT    = 0;
  localparam int STAT_HALT_BIT     = 1;
  localparam int STAT_SLEEP_BIT    = 2;
  localparam int STAT_TXFIFO_BIT   = 3;
  localparam int ERR_MODE_BIT      = 7;
  localparam int TEST_ENABLE_BIT   = 0;
  localparam int TEST_SELECT_LSB   = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h41;
  localparam logic [7:0]  TEST_RESET  = 8'h00;
  localparam logic [6:0]  ERR_RESET   = 7'h00;
  localparam logic [15:0] STAMP_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Codes
  localparam logic [1:0] OPMODE_OPER  = 2'h0;
  localparam logic [1:0] OPMODE_RESET = 2'h1;
  localparam logic [1:0] OPMODE_HALT  = 2'h2;
  localparam logic [1:0] BUSOFF_NORMAL     = 2'h0;
  localparam logic [1:0] BUSOFF_AUTO_ENTRY = 2'h1;
  localparam logic [1:0] BUSOFF_AUTO_END   = 2'h2;
  localparam logic [1:0] BUSOFF_PROGRAM    = 2'h3;
  localparam logic [1:0] TEST_LISTEN   = 2'h1;
  localparam logic [1:0] TEST_EXT_LOOP = 2'h2;
  localparam logic [1:0] TEST_INT_LOOP = 2'h3;

  typedef enum logic [1:0] {
    MODE_OPER,
    MODE_RESET,
    MODE_HALT,
    MODE_SLEEP
  } mode_e;

  // Packed so that the cast gives bit 0 = stuff ... bit 6 = ack delimiter
  typedef struct packed {
    logic ack_delim;
    logic dom_bit;
    logic rec_bit;
    logic crc;
    logic ack;
    logic form;
    logic stuff;
  } err_events_s;

  typedef struct packed {
    logic rx_active;
    logic rx_done;
    logic tx_active;
    logic tx_done;
    logic bus_error;
    logic arb_lost;
    logic bus_off;
    logic bus_off_recovered;
  } proto_state_s;

endpackage

// [verilog/stamp_counter.sv]
// Prescaled free-running time stamp counter
`timescale 1ns/1ps
module stamp_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,      // Module clock
  input  wire logic             reset_n_i,  // Synchronous reset, active low
  input  wire logic             bit_tick_i, // One pulse per bit time
  input  wire logic [1:0]       prescale_i, // Bit times per count, 2**prescale
  input  wire logic             run_i,      // Count enable
  input  wire logic             clear_i,    // Hold at initial value
  output logic      [WIDTH-1:0] value_o     // Counter value
);
  import can_mode_pkg::*;

  function automatic logic [2:0] last_tick(input logic [1:0] ps);
    last_tick = 3'((4'h1 << ps) - 4'h1);
  endfunction

  logic [2:0] div_reg;
  logic [2:0] div_next;
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  wire  wrap = bit_tick_i & (div_reg >= last_tick(prescale_i));

  always_comb begin
    div_next   = div_reg;
    count_next = count_reg;
    if (clear_i) begin
      div_next   = 3'h0;
      count_next = WIDTH'(STAMP_RESET);
    end else if (run_i && bit_tick_i) begin
      div_next = wrap ? 3'h0 : div_reg + 3'h1;
      if (wrap) begin
        count_next = count_reg + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      div_reg   <= 3'h0;
      count_reg <= WIDTH'(STAMP_RESET);
    end else begin
      div_reg   <= div_next;
      count_reg <= count_next;
    end
  end

  assign value_o = count_reg;
endmodule

// [verilog/error_capture.sv]
// Sticky error code flags, first-error and accumulated views
`timescale 1ns/1ps
module error_capture (
  input  wire logic                      clk_i,      // Module clock
  input  wire logic                      reset_n_i,  // Synchronous reset, active low
  input  wire can_mode_pkg::err_events_s events_i,   // Error detections, pulses
  input  wire logic [6:0]                clear_i,    // Flags written with 0
  input  wire logic                      hold_i,     // Reset mode, hold cleared
  output logic      [6:0]                accum_o,    // Accumulated code
  output logic      [6:0]                first_o     // First captured code
);
  import can_mode_pkg::*;

  logic [6:0] accum_reg;
  logic [6:0] first_reg;
  wire  [6:0] set_bits   = 7'(events_i);
  wire  [6:0] accum_kept = accum_reg & ~clear_i;
  wire  [6:0] first_kept = first_reg & ~clear_i;
  wire  [6:0] accum_next = accum_kept | set_bits;
  wire  [6:0] first_next = (first_kept == 7'h00) ? set_bits : first_kept;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || hold_i) begin
      accum_reg <= ERR_RESET;
      first_reg <= ERR_RESET;
    end else begin
      accum_reg <= accum_next;
      first_reg <= first_next;
    end
  end

  assign accum_o = accum_reg;
  assign first_o = first_reg;
endmodule

// [verilog/can_mode_control.sv]
// CAN mode control, test modes, time stamp and error code capture with APB registers
//
// Functional notes
// - CRC, recessive-bit and dominant-bit error flags set on detection.
// - Ack delimiter error flag sets on form error while transmitting.
// - Output mode 0 shows first error code; 1 shows accumulated codes.
// - Free-running 16-bit stamp counter; read returns current value.
// - Stamp advances once per prescaled multiple of bit time.
// - Stamp holds in sleep and halt, clears in reset mode.
// - Received message store copies stamp low and high bytes to mailbox.
// - Test enable 0 disables test modes; 1 activates selected mode.
// - Listen-only receives but drives recessive; no ack, overload, active error.
// - External loopback stores own frames as received, self-generates ack.
// - Internal loopback feeds tx to rx, pin recessive, self ack.
// - Operating mode 01b enters reset mode and sets reset status.
// - Reset mode restores and holds status, flags, stamp, test control.
// - Reset mode keeps control and error output mode bit.
// - Operating mode 10b enters halt; only mode status bits change.
// - Reset immediate in reception and bus-off; waits for transmission end.
// - Halt waits for ongoing reception or transmission to end.
// - Bus-off handling field selects when halt is entered during bus-off.
// - With transmissions pending, mode change follows first completed transmission.
// - Bus error or lost arbitration after request enters the requested mode.
// - Test select 10b is external loopback, 11b internal loopback.
// - Error flags clear by writing 0; a simultaneous set wins.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module can_mode_control (
  input  wire logic                       clk_i,              // 200 MHz module clock
  input  wire logic                       reset_n_i,          // Sync reset, active low
  // APB slave
  input  wire logic                       psel_i,             // Select
  input  wire logic                       penable_i,          // Access phase
  input  wire logic                       pwrite_i,           // Write direction
  input  wire logic [7:0]                 paddr_i,            // Byte address
  input  wire logic [31:0]                pwdata_i,           // Write data
  output logic      [31:0]                prdata_o,           // Read data
  output logic                            pready_o,           // Transfer done
  output logic                            pslverr_o,          // Unmapped address
  // Protocol engine
  input  wire can_mode_pkg::err_events_s  events_i,           // Error detections
  input  wire can_mode_pkg::proto_state_s proto_i,            // Frame and bus state
  input  wire logic                       bit_tick_i,         // One pulse per bit
  input  wire logic                       tx_fifo_status_i,   // Transmit FIFO status
  input  wire logic                       rx_store_i,         // Frame stored, pulse
  input  wire logic [4:0]                 rx_store_box_i,     // Receiving mailbox
  input  wire logic                       core_tx_i,          // Engine transmit bit
  output logic                            core_rx_o,          // Engine receive bit
  output logic                            self_ack_o,         // Generate own ack
  output logic                            listen_only_o,      // Suppress dominant output
  output logic                            reset_mode_o,       // Reset mode active
  output logic                            halt_mode_o,        // Halt mode active
  output logic                            sleep_mode_o,       // Sleep mode active
  // Mailbox time stamp write
  output logic                            stamp_write_o,      // Stamp store, pulse
  output logic      [4:0]                 stamp_box_o,        // Target mailbox
  output logic      [7:0]                 stamp_low_byte_o,   // Stamp bits 7:0
  output logic      [7:0]                 stamp_high_byte_o,  // Stamp bits 15:8
  // Bus pins
  input  wire logic                       bus_receive_pin_i,  // Receive pin
  output logic                            bus_transmit_pin_o  // Transmit pin
);
  import can_mode_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [7:0]  test_reg;
  logic [7:0]  test_next;
  logic        err_mode_reg;
  logic [3:0]  status_reg;
  mode_e       mode_reg;
  mode_e       mode_next;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        rx_sync1_reg;
  logic        rx_sync2_reg;
  logic        core_rx_reg;
  logic        tx_pin_reg;
  logic        self_ack_reg;
  logic        listen_reg;
  logic        stamp_write_reg;
  logic [4:0]  stamp_box_reg;
  logic [15:0] stamp_hold_reg;
  logic [15:0] stamp_value;
  logic [6:0]  err_accum;
  logic [6:0]  err_first;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire access    = psel_i & penable_i;
  wire take      = access & pready_reg;
  wire wr_take   = take & pwrite_i;
  wire hit_ctrl  = (paddr_i == ADDR_CTRL);
  wire hit_stat  = (paddr_i == ADDR_STATUS);
  wire hit_err   = (paddr_i == ADDR_ERRCODE);
  wire hit_stamp = (paddr_i == ADDR_STAMP);
  wire hit_test  = (paddr_i == ADDR_TEST);
  wire mapped    = hit_ctrl | hit_stat | hit_err | hit_stamp | hit_test;
  wire wr_ctrl   = wr_take & hit_ctrl;
  wire wr_err    = wr_take & hit_err;
  wire wr_test   = wr_take & hit_test;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields
  wire [1:0] opmode   = ctrl_reg[CTRL_OPMODE_LSB +: 2];
  wire [1:0] busoff_h = ctrl_reg[CTRL_BUSOFF_LSB +: 2];
  wire [1:0] prescale = ctrl_reg[CTRL_PRESCALE_LSB +: 2];
  wire       sleep_rq = ctrl_reg[CTRL_SLEEP_BIT];
  wire       req_oper  = (opmode == OPMODE_OPER);
  wire       req_reset = (opmode == OPMODE_RESET);
  wire       req_halt  = (opmode == OPMODE_HALT);

  wire in_oper  = (mode_reg == MODE_OPER);
  wire in_reset = (mode_reg == MODE_RESET);
  wire in_halt  = (mode_reg == MODE_HALT);
  wire in_sleep = (mode_reg == MODE_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // Mode request acceptance
  // Transmission ends normally, or is cut short by an error or lost arbitration
  wire tx_release = ~proto_i.tx_active | proto_i.tx_done
                  | proto_i.bus_error | proto_i.arb_lost;
  wire rx_release = ~proto_i.rx_active | proto_i.rx_done
                  | proto_i.bus_error;
  // Reception and bus-off do not delay reset
  wire reset_ok = tx_release | proto_i.bus_off;
  wire halt_ok_frame = tx_release & rx_release;
  // During bus-off only the program-halt setting accepts a halt request at once
  wire halt_ok = proto_i.bus_off ? (busoff_h == BUSOFF_PROGRAM)
                                 : halt_ok_frame;
  wire auto_halt = in_oper & (
      ((busoff_h == BUSOFF_AUTO_ENTRY) & proto_i.bus_off) |
      ((busoff_h == BUSOFF_AUTO_END) & proto_i.bus_off_recovered));

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MODE_OPER: begin
        if (req_reset && reset_ok) begin
          mode_next = MODE_RESET;
        end else if ((req_halt && halt_ok) || auto_halt) begin
          mode_next = MODE_HALT;
        end
      end
      MODE_RESET: begin
        if (sleep_rq) begin
          mode_next = MODE_SLEEP;
        end else if (req_halt) begin
          mode_next = MODE_HALT;
        end else if (req_oper) begin
          mode_next = MODE_OPER;
        end
      end
      MODE_HALT: begin
        if (sleep_rq) begin
          mode_next = MODE_SLEEP;
        end else if (req_reset) begin
          mode_next = MODE_RESET;
        end else if (req_oper) begin
          mode_next = MODE_OPER;
        end
      end
      MODE_SLEEP: begin
        if (!sleep_rq) begin
          if (req_reset) begin
            mode_next = MODE_RESET;
          end else if (req_halt) begin
            mode_next = MODE_HALT;
          end else if (req_oper) begin
            mode_next = MODE_OPER;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; automatic halt records itself in the mode field
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = pwdata_i[7:0];
      ctrl_next[7] = 1'b0;
    end
    if (auto_halt) begin
      ctrl_next[CTRL_OPMODE_LSB +: 2] = OPMODE_HALT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test control, held cleared in reset mode
  always_comb begin
    test_next = test_reg;
    if (wr_test) begin
      test_next = {5'h00, pwdata_i[2:0]};
    end
    if (in_reset) begin
      test_next = TEST_RESET;
    end
  end

  wire       test_en  = test_reg[TEST_ENABLE_BIT];
  wire [1:0] test_sel = test_reg[TEST_SELECT_LSB +: 2];
  wire       t_listen = test_en & (test_sel == TEST_LISTEN);
  wire       t_ext    = test_en & (test_sel == TEST_EXT_LOOP);
  wire       t_int    = test_en & (test_sel == TEST_INT_LOOP);

  ////////////////////////////////////////////////////////////////////////////
  // Pin path
  wire rx_to_core = t_int ? core_tx_i : rx_sync2_reg;
  wire tx_to_pin  = (t_listen | t_int) ? 1'b1 : core_tx_i;

  ////////////////////////////////////////////////////////////////////////////
  // Error code capture and time stamp
  wire [6:0] err_clear = wr_err ? ~pwdata_i[6:0] : 7'h00;
  wire [6:0] err_view  = err_mode_reg ? err_accum : err_first;

  error_capture u_error_capture (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .events_i  (events_i),
    .clear_i   (err_clear),
    .hold_i    (in_reset),
    .accum_o   (err_accum),
    .first_o   (err_first)
  );

  stamp_counter #(
    .WIDTH (16)
  ) u_stamp_counter (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .bit_tick_i (bit_tick_i),
    .prescale_i (prescale),
    .run_i      (in_oper),
    .clear_i    (in_reset),
    .value_o    (stamp_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [3:0] status_view = status_reg;
  wire [31:0] rd_mux =
      hit_ctrl  ? {24'h00_0000, ctrl_reg} :
      hit_stat  ? {28'h000_0000, status_view} :
      hit_err   ? {24'h00_0000, err_mode_reg, err_view} :
      hit_stamp ? {16'h0000, stamp_value} :
      hit_test  ? {24'h00_0000, test_reg} :
                  32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_reg     <= MODE_SLEEP;
      ctrl_reg     <= CTRL_RESET;
      test_reg     <= TEST_RESET;
      err_mode_reg <= 1'b0;
      status_reg   <= 4'h4;
    end else begin
      mode_reg   <= mode_next;
      ctrl_reg   <= ctrl_next;
      test_reg   <= test_next;
      if (wr_err) begin
        err_mode_reg <= pwdata_i[ERR_MODE_BIT];
      end
      // Only the mode status bits follow the mode
      status_reg[STAT_RESET_BIT]  <= (mode_next == MODE_RESET);
      status_reg[STAT_HALT_BIT]   <= (mode_next == MODE_HALT);
      status_reg[STAT_SLEEP_BIT]  <= (mode_next == MODE_SLEEP);
      status_reg[STAT_TXFIFO_BIT] <= tx_fifo_status_i;
    end
  end

  // One wait state: ready in the second access cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~mapped;
      if (access && !pready_reg && !pwrite_i) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_sync1_reg <= 1'b1;
      rx_sync2_reg <= 1'b1;
      core_rx_reg  <= 1'b1;
      tx_pin_reg   <= 1'b1;
      self_ack_reg <= 1'b0;
      listen_reg   <= 1'b0;
    end else begin
      rx_sync1_reg <= bus_receive_pin_i;
      rx_sync2_reg <= rx_sync1_reg;
      core_rx_reg  <= rx_to_core;
      tx_pin_reg   <= tx_to_pin;
      self_ack_reg <= t_ext | t_int;
      listen_reg   <= t_listen;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stamp_write_reg <= 1'b0;
      stamp_box_reg   <= 5'h00;
      stamp_hold_reg  <= STAMP_RESET;
    end else begin
      stamp_write_reg <= rx_store_i;
      if (rx_store_i) begin
        stamp_box_reg  <= rx_store_box_i;
        stamp_hold_reg <= stamp_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata_o           = prdata_reg;
  assign pready_o           = pready_reg;
  assign pslverr_o          = pslverr_reg;
  assign core_rx_o          = core_rx_reg;
  assign bus_transmit_pin_o = tx_pin_reg;
  assign self_ack_o         = self_ack_reg;
  assign listen_only_o      = listen_reg;
  assign reset_mode_o       = status_reg[STAT_RESET_BIT];
  assign halt_mode_o        = status_reg[STAT_HALT_BIT];
  assign sleep_mode_o       = status_reg[STAT_SLEEP_BIT];
  assign stamp_write_o      = stamp_write_reg;
  assign stamp_box_o        = stamp_box_reg;
  assign stamp_low_byte_o   = stamp_hold_reg[7:0];
  assign stamp_high_byte_o  = stamp_hold_reg[15:8];
endmodule

// [verif/can_mode_control_monitor.sv]
// Port-level checker for the CAN mode control block
`timescale 1ns/1ps
module can_mode_control_monitor import can_mode_pkg::*; (
  input wire logic                       clk_i,              // Clock
  input wire logic                       reset_n_i,          // Sync reset
  input wire logic                       psel_i,             // Select
  input wire logic                       penable_i,          // Access phase
  input wire logic                       pwrite_i,           // Direction
  input wire logic [7:0]                 paddr_i,            // Address
  input wire logic [31:0]                pwdata_i,           // Write data
  input wire logic                       pready_o,           // Transfer done
  input wire can_mode_pkg::proto_state_s proto_i,            // Bus state
  input wire logic                       rx_store_i,         // Frame stored
  input wire logic [4:0]                 rx_store_box_i,     // Store mailbox
  input wire logic                       core_tx_i,          // Engine tx bit
  input wire logic                       listen_only_o,      // Listen-only
  input wire logic                       self_ack_o,         // Own ack
  input wire logic                       bus_transmit_pin_o, // Tx pin
  input wire logic                       stamp_write_o,      // Stamp store
  input wire logic [4:0]                 stamp_box_o,        // Stamp mailbox
  input wire logic [7:0]                 stamp_low_byte_o,   // Stamp low
  input wire logic [7:0]                 stamp_high_byte_o,  // Stamp high
  input wire logic                       reset_mode_o,       // Reset mode
  input wire logic                       halt_mode_o         // Halt mode
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////
  a_pready_wait: assert property (psel_i && $rose(penable_i) |=> pready_o)
    else $error("no ready in second access cycle");
  a_pready_single: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_stamp_store: assert property (rx_store_i |=> stamp_write_o &&
    stamp_box_o == $past(rx_store_box_i)) else $error("stamp store missing");
  a_reset_stamp: assert property (reset_mode_o && $past(reset_mode_o) && rx_store_i
    |=> {stamp_high_byte_o, stamp_low_byte_o} == STAMP_RESET) else $error("stamp not clear");
  a_listen_recessive: assert property (listen_only_o && $past(listen_only_o)
    |-> bus_transmit_pin_o) else $error("dominant bit in listen-only");
  a_pin_follows: assert property (!listen_only_o && !self_ack_o && !$past(listen_only_o)
    && !$past(self_ack_o) |-> bus_transmit_pin_o == $past(core_tx_i))
    else $error("tx pin does not follow engine");
  a_reset_entry: assert property (psel_i && penable_i && pready_o && pwrite_i
    && paddr_i == ADDR_CTRL && pwdata_i[1:0] == OPMODE_RESET && !pwdata_i[CTRL_SLEEP_BIT]
    && !proto_i.tx_active |-> ##[1:4] reset_mode_o) else $error("reset mode not entered");
  a_halt_cause: assert property ($rose(halt_mode_o) |-> !$past(proto_i.tx_active)
    || $past(proto_i.tx_done) || $past(proto_i.bus_error) || $past(proto_i.arb_lost)
    || $past(proto_i.bus_off)) else $error("halt entered during transmission");
endmodule

bind can_mode_control can_mode_control_monitor mon (.*);

// [verif/can_bus_node.sv]
// Far-side bus node: wired-AND bus line and bit time ticks
`timescale 1ns/1ps
module can_bus_node #(
  parameter int BIT_CYCLES = 4
) (
  input  wire logic clk_i,       // Module clock
  input  wire logic dut_tx_i,    // Device transmit pin
  input  wire logic node_tx_i,   // Bit of this node, 0 dominant
  output logic      bus_level_o, // Level seen by every receiver
  output logic      bit_tick_o   // One pulse per bit time
);
  int cnt = 0;
  // Dominant wins on the shared line
  assign bus_level_o = dut_tx_i & node_tx_i;
  assign bit_tick_o = (cnt == BIT_CYCLES - 1);
  always @(posedge clk_i) cnt <= bit_tick_o ? 0 : cnt + 1;
endmodule

// [verif/can_mode_control_test.sv]
// Register-level self-checking tests of the CAN mode control block
`timescale 1ns/1ps
module can_mode_control_test;
  import can_mode_pkg::*;
  logic clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, er, ls, sa;
  logic tx_fifo_status_i = 1, rx_store_i = 0, core_tx_i = 1, node_tx = 1;
  logic [7:0] paddr_i = '0, stamp_low_byte_o, stamp_high_byte_o;
  logic [31:0] pwdata_i = '0, rd, prdata_o;
  logic [4:0] rx_store_box_i = '0, stamp_box_o;
  logic [15:0] s1;
  err_events_s events_i = '0;
  proto_state_s proto_i = '0;
  logic pready_o, pslverr_o, core_rx_o, self_ack_o, listen_only_o, reset_mode_o, halt_mode_o;
  logic sleep_mode_o, stamp_write_o, bus_transmit_pin_o, bit_tick_i, bus_receive_pin_i;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  always #2.5 clk_i = ~clk_i;
  can_mode_control DUT (.*);
  can_bus_node node (.clk_i(clk_i), .dut_tx_i(bus_transmit_pin_o), .node_tx_i(node_tx),
    .bus_level_o(bus_receive_pin_i), .bit_tick_o(bit_tick_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i) penable_i <= 1;
    do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 40);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0; penable_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, '0);
    chk(rd, e);
  endtask
  task automatic wait_status(input logic [31:0] e);
    int n;
    n = 0;
    do begin apb(0, ADDR_STATUS, '0); n++; end while (rd !== e && n < 30);
    chk(rd, e);
  endtask
  task automatic rate(input logic [31:0] c, input int gap, lo, hi);
    apb(1, ADDR_CTRL, c);
    apb(0, ADDR_STAMP, '0);
    s1 = rd[15:0];
    wt(gap);
    apb(0, ADDR_STAMP, '0);
    chk({31'h0, (rd[15:0] - s1) inside {[lo:hi]}}, 32'h1);
  endtask
  task automatic store(input logic [4:0] b);
    rx_store_box_i <= b;
    rx_store_i <= 1;
    @(posedge clk_i) rx_store_i <= 0;
    wt(2);
  endtask
  task automatic pulse(input logic [6:0] e);
    events_i <= e;
    @(posedge clk_i) events_i <= '0;
    wt(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(6);
    reset_n_i <= 1;
    wt(1);
    rdchk(ADDR_CTRL, 32'h41);
    rdchk(ADDR_STATUS, 32'hC);
    rdchk(ADDR_TEST, 32'h0);
    rdchk(ADDR_ERRCODE, 32'h0);
    apb(0, 8'h14, '0);
    chk({31'h0, er}, 32'h1);
    apb(1, ADDR_CTRL, 32'h1);
    wait_status(32'h9);
    apb(1, ADDR_TEST, 32'h3);
    rdchk(ADDR_TEST, 32'h0);
    $display("test reset entry done");
    apb(1, ADDR_CTRL, 32'h0);
    wait_status(32'h8);
    rate(32'h0, 40, 10, 12);
    rate(32'h20, 80, 4, 6);
    $display("test stamp rate done");
    pulse(7'h08);
    pulse(7'h20);
    rdchk(ADDR_ERRCODE, 32'h08);
    apb(1, ADDR_ERRCODE, 32'hFF);
    rdchk(ADDR_ERRCODE, 32'hA8);
    pulse(7'h50);
    rdchk(ADDR_ERRCODE, 32'hF8);
    apb(1, ADDR_ERRCODE, 32'hF7);
    rdchk(ADDR_ERRCODE, 32'hF0);
    proto_i.rx_active <= 1;
    apb(1, ADDR_CTRL, 32'h21);
    wait_status(32'h9);
    proto_i.rx_active <= 0;
    rdchk(ADDR_ERRCODE, 32'h80);
    rdchk(ADDR_STAMP, 32'h0);
    rdchk(ADDR_CTRL, 32'h21);
    store(5'h0);
    chk({11'h0, stamp_box_o, stamp_high_byte_o, stamp_low_byte_o}, 32'h0);
    $display("test error capture done");
    apb(1, ADDR_CTRL, 32'h0);
    wait_status(32'h8);
    for (int i = 0; i < 8; i++) begin
      apb(1, ADDR_TEST, 32'(i));
      ls = i[0] && i[2:1] == 2'h1;
      sa = i[0] && i[2:1] >= 2'h2;
      core_tx_i <= 0;
      wt(6);
      chk({listen_only_o, self_ack_o, bus_transmit_pin_o, core_rx_o},
        {ls, sa, ls | (sa & i[1]), ls});
      core_tx_i <= 1;
      wt(6);
    end
    apb(1, ADDR_TEST, 32'h0);
    $display("test modes done");
    proto_i.tx_active <= 1;
    apb(1, ADDR_CTRL, 32'h6);
    wt(5);
    chk({31'h0, halt_mode_o}, 32'h0);
    proto_i.tx_active <= 0;
    proto_i.tx_done <= 1;
    wt(1);
    proto_i.tx_done <= 0;
    wait_status(32'hA);
    apb(0, ADDR_STAMP, '0);
    s1 = rd[15:0];
    wt(20);
    rdchk(ADDR_STAMP, {16'h0, s1});
    store(5'h1F);
    chk({11'h0, stamp_box_o, stamp_high_byte_o, stamp_low_byte_o}, {16'h1F, s1});
    $display("test halt done");
    apb(1, ADDR_CTRL, 32'h4);
    wait_status(32'h8);
    proto_i.bus_off <= 1;
    wt(4);
    chk({31'h0, halt_mode_o}, 32'h1);
    proto_i.bus_off <= 0;
    rdchk(ADDR_CTRL, 32'h6);
    $display("test bus-off halt done");
    apb(1, ADDR_CTRL, 32'h4);
    wait_status(32'h8);
    proto_i.tx_active <= 1;
    apb(1, ADDR_CTRL, 32'h5);
    wt(5);
    chk({31'h0, reset_mode_o}, 32'h0);
    proto_i.bus_error <= 1;
    wt(1);
    proto_i.bus_error <= 0;
    wait_status(32'h9);
    proto_i.tx_active <= 0;
    $display("test cut transmission done");
    tally_and_finish();
  end
endmodule
